/* File: rcss_defs.vh */
// Constants shared by the recovered clock select and squelch block.
`ifndef RCSS_DEFS_VH
`define RCSS_DEFS_VH

// Register byte addresses.
`define RCSS_ADDR_CFG_BASE    8'h00
`define RCSS_ADDR_PLLCFG_BASE 8'h20
`define RCSS_ADDR_HSOUT       8'h40
`define RCSS_ADDR_PHYCTRL0    8'h44
`define RCSS_ADDR_PHYCTRL1    8'h48
`define RCSS_ADDR_LANE1G      8'h4C
`define RCSS_ADDR_LANE6G      8'h50
`define RCSS_ADDR_STATUS      8'h54

// Address bit fields used by the decoder.
`define RCSS_ADDR_IDX_HI      4
`define RCSS_ADDR_IDX_LO      2
`define RCSS_ADDR_GRP_HI      7
`define RCSS_ADDR_GRP_LO      5
`define RCSS_GRP_CFG          3'h0
`define RCSS_GRP_PLLCFG       3'h1

// recovered_clock_config fields.
`define RCSS_CFG_ENA          0
`define RCSS_CFG_DIV_LO       1
`define RCSS_CFG_DIV_HI       3
`define RCSS_CFG_SRC_LO       4
`define RCSS_CFG_SRC_HI       7
`define RCSS_CFG_RESET        8'h00

// recovered_clock_pll_config fields.
`define RCSS_PLLCFG_LOCKSQ    0

// highspeed_pll_output_config fields.
`define RCSS_HS_SEL_HI        1
`define RCSS_HS_SEL_LO        0
`define RCSS_HS_SEL_OFF       2'h0
`define RCSS_HS_SEL_CORE      2'h1

// phy_recovered_clock_ctrl fields.
`define RCSS_PHY_ENA          0
`define RCSS_PHY_NUM_LO       1
`define RCSS_PHY_NUM_HI       2
`define RCSS_PHY_FREQ         3
`define RCSS_PHY_MODE         4
`define RCSS_PHY_RESET        5'h00

// Lane squelch enable widths.
`define RCSS_LANE1G_N         6
`define RCSS_LANE6G_N         3

// Source select codes.
`define RCSS_SRC_LANE_BASE    4'h2
`define RCSS_SRC_PLL          4'hB
`define RCSS_SRC_SQ_LAST      4'h8

// Divider select codes.
`define RCSS_DIV_1            3'h0
`define RCSS_DIV_2            3'h1
`define RCSS_DIV_4            3'h2
`define RCSS_DIV_5            3'h3
`define RCSS_DIV_8            3'h4
`define RCSS_DIV_16           3'h5
`define RCSS_DIV_25           3'h6

`endif

/* File: rcss_divider.v */
// Per-output clock divider with enable and squelch freeze.
`timescale 1ns/1ps
`default_nettype none
`include "rcss_defs.vh"

module rcss_divider (
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Selected source level and configuration
  input  wire       src_level,
  input  wire       enable,
  input  wire [2:0] div_code,
  input  wire       squelch,
  // Divided clock
  output reg        clk_out
);

  reg       src_prev;
  reg [4:0] count;
  reg [4:0] div_last;
  reg [4:0] div_half;

  always @* begin
    case (div_code) // [R04]
      `RCSS_DIV_2:  div_last = 5'd1;
      `RCSS_DIV_4:  div_last = 5'd3;
      `RCSS_DIV_5:  div_last = 5'd4;
      `RCSS_DIV_8:  div_last = 5'd7;
      `RCSS_DIV_16: div_last = 5'd15;
      `RCSS_DIV_25: div_last = 5'd24;
      default:      div_last = 5'd0;
    endcase
    div_half = (div_last + 5'd1) >> 1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev <= 1'b0;
      count    <= 5'd0;
      clk_out  <= 1'b0;
    end else begin
      src_prev <= src_level;
      if (!enable) begin
        count   <= 5'd0; // [R17]
        clk_out <= 1'b0; // [R17]
      end else if (squelch) begin
        // Freeze at whatever level the output had.
        count   <= count; // [R15]
        clk_out <= clk_out; // [R15]
      end else if (div_last == 5'd0) begin
        clk_out <= src_level;
      end else if (src_level && !src_prev) begin
        if (count >= div_last) begin
          count   <= 5'd0;
          clk_out <= 1'b1;
        end else begin
          count   <= count + 5'd1;
          clk_out <= ((count + 5'd1) < div_half);
        end
      end
    end
  end

endmodule // rcss_divider

`default_nettype wire

/* File: rcss_sva.sv */
// Bus and output checks for the recovered clock block.
`timescale 1ns/1ps
`default_nettype none
module rcss_sva (
  // Bus side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Clock outputs
  input wire logic [7:0]  recovered_clock,
  input wire logic        recovered_clock_pin_0,
  input wire logic        recovered_clock_pin_0_oe,
  input wire logic        highspeed_clock_pin
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       wr;
  logic [1:0] hs_sel;
  logic [7:0] en;
  logic [7:0] en1;
  logic [7:0] en2;
  logic [7:0] en3;
  assign wr = psel && penable && pready && pwrite && !pslverr;
  // Shadow of the enables, delayed so the output pipeline may settle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_sel <= 2'h0;
      en <= 8'h00;
      en1 <= 8'h00;
      en2 <= 8'h00;
      en3 <= 8'h00;
    end else begin
      if (wr && paddr == 8'h40) hs_sel <= pwdata[1:0];
      if (wr && paddr[7:5] == 3'h0) en[paddr[4:2]] <= pwdata[0];
      en1 <= en;
      en2 <= en1;
      en3 <= en2;
    end
  end
  pready_timing_a: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (
    (!pready || pslverr) |-> prdata == 32'h0000_0000)
    else $error("prdata not zero");
  refused_a: assert property (psel && penable && pready &&
    (paddr[1:0] != 2'h0 || paddr > 8'h54 || (pwrite && paddr == 8'h54))
    |-> pslverr) else $error("bad access not refused");
  pin_follow_a: assert property (
    $rose(recovered_clock[0]) |-> ##[0:1] $rose(recovered_clock_pin_0))
    else $error("pin 0 does not follow output 0");
  oe_match_a: assert property (
    en1[0] == en2[0] |-> recovered_clock_pin_0_oe == en1[0])
    else $error("pin 0 enable differs from entry 0");
  hs_off_a: assert property (
    (hs_sel != 2'h1) [*3] |-> !highspeed_clock_pin)
    else $error("high speed pin active while deselected");
  dis_static_a: assert property (
    ((~(en | en1 | en2 | en3)) & recovered_clock) == 8'h00)
    else $error("disabled output not static low");
endmodule // rcss_sva
bind rcss_top rcss_sva i_rcss_sva (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .recovered_clock, .recovered_clock_pin_0,
  .recovered_clock_pin_0_oe, .highspeed_clock_pin
);
`default_nettype wire

/* File: rcss_sync3.v */
// Three flip-flop synchroniser with agreement filter for pin inputs.
`timescale 1ns/1ps
`default_nettype none

module rcss_sync3 #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // Asynchronous input and filtered level
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] level
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;
  reg [W-1:0] stage3;

  // The level moves only once the second and third stages agree.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= {W{1'b0}};
      stage2 <= {W{1'b0}};
      stage3 <= {W{1'b0}};
      level  <= {W{1'b0}};
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      // Where the two stages disagree the bit is still settling, so the
      // old level is kept; where they agree the new level is taken.
      level  <= (stage3 & ~(stage2 ^ stage3)) | (level & (stage2 ^ stage3));
    end
  end

endmodule // rcss_sync3

`default_nettype wire

/* File: rcss_timing_model.sv */
// Model of the external timing equipment fed by the clock pins.
`timescale 1ns/1ps
`default_nettype none
module rcss_timing_model (
  // Clock
  input  wire logic       pclk,
  // Pin levels: pin 0, pin 1, high speed pin
  input  wire logic [2:0] clk_pin,
  // Rising edge counts and last period in clock cycles
  output int              rise [3],
  output int              per [3]
);
  logic [2:0] last = 3'h0;
  int         r [3] = '{0, 0, 0};
  int         p [3] = '{0, 0, 0};
  int         since [3] = '{0, 0, 0};
  assign rise = r;
  assign per = p;
  // Equipment only watches edges; it never drives the pins back.
  always @(posedge pclk) begin
    last <= clk_pin;
    for (int i = 0; i < 3; i++) begin
      since[i] <= since[i] + 1;
      if (clk_pin[i] && !last[i]) begin
        r[i] <= r[i] + 1;
        p[i] <= since[i] + 1;
        since[i] <= 0;
      end
    end
  end
endmodule // rcss_timing_model
`default_nettype wire

/* File: rcss_top.v */
// Recovered clock selection, division and squelch with APB registers.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rcss_defs.vh"

// Notes on behaviour
// [R01] Eight recovered clocks: four external, four internal; the code gives pins to entries 0 and 1 only.
// [R02] Each output has its own configuration register.
// [R03] Any copper or lane rate may source clock; the code passes copper only with frequency and mode selects both set.
// [R04] Divide by 1, 2, 4, 5, 8, 16, 25.
// [R05] Pins 0 and 1 follow entries 0 and 1.
// [R06] Two copper resources pick copper PHY 0-3.
// [R07] Software configures copper path for 31.25 MHz.
// [R08] Software uses lane plus two, divider code 1.
// [R09] Lanes 7-8 at 2.5G use divider code 4.
// [R10] Source code eleven selects the PLL clock.
// [R11] High-speed output copies core clock when selected.
// [R12] Auto squelch on loss of source signal.
// [R13] Sources 0-5 use 1G lane squelch bits.
// [R14] Sources 6-8 use 6G lane squelch bits.
// [R15] Squelch stops clock on signal or lock loss.
// [R16] Software disables squelch for 100 Mbit lanes.
// [R17] Disabled output static; writes affect own entry.
module rcss_top #(
  parameter N_OUT  = 8,
  parameter N_PHY  = 4,
  parameter N_LANE = 9
) (
  // APB clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Receive clocks and line status from pins
  input  wire [3:0]  copper_phy_rx_clock,
  input  wire [8:0]  lane_rx_clock,
  input  wire        pll_clock,
  input  wire        pll_lock,
  input  wire [8:0]  lane_loss_of_signal,
  input  wire [3:0]  copper_phy_loss_of_signal,
  // Recovered clock outputs
  output reg  [7:0]  recovered_clock,
  output reg         recovered_clock_pin_0,
  output reg         recovered_clock_pin_0_oe,
  output reg         recovered_clock_pin_1,
  output reg         recovered_clock_pin_1_oe,
  output reg         highspeed_clock_pin
);

  // Configuration storage.
  reg  [7:0]  recovered_clock_config     [0:7];
  reg  [7:0]  recovered_clock_pll_config;
  reg  [1:0]  highspeed_output_select;
  reg  [4:0]  phy_recovered_clock_ctrl_0;
  reg  [4:0]  phy_recovered_clock_ctrl_1;
  reg  [5:0]  lane_1g_auto_squelch_enable;
  reg  [2:0]  lane_6g_auto_squelch_enable;

  // Synchronised inputs.
  wire [3:0]  copper_lvl;
  wire [8:0]  lane_lvl;
  wire        pll_lvl;
  wire        lock_lvl;
  wire [8:0]  lane_los;
  wire [3:0]  copper_los;

  // Derived per-source views.
  reg  [15:0] source_level;
  reg  [15:0] source_los;
  reg  [15:0] source_sq_enable;
  reg         copper_res_0;
  reg         copper_res_1;
  reg         copper_los_0;
  reg         copper_los_1;
  wire [7:0]  div_out;
  wire [7:0]  squelch_active;

  // APB decode.
  wire        setup_phase;
  wire        write_take;
  wire [2:0]  reg_idx;
  wire [2:0]  reg_grp;
  reg  [31:0] next_prdata;
  reg         next_pslverr;
  integer     k;
  integer     j;

  rcss_sync3 #(
    .W (1 + 1 + 4 + 9 + 9 + 4)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({pll_clock, pll_lock, copper_phy_rx_clock, lane_rx_clock,
                lane_loss_of_signal, copper_phy_loss_of_signal}),
    .level    ({pll_lvl, lock_lvl, copper_lvl, lane_lvl, lane_los,
                copper_los})
  );

  // Copper resources: a resource passes its chosen PHY only when enabled
  // with both frequency and mode selects set, otherwise it rests low.
  always @* begin
    copper_res_0 = 1'b0;
    copper_res_1 = 1'b0;
    copper_los_0 = 1'b1;
    copper_los_1 = 1'b1;
    if (phy_recovered_clock_ctrl_0[`RCSS_PHY_ENA] &&
        phy_recovered_clock_ctrl_0[`RCSS_PHY_FREQ] &&
        phy_recovered_clock_ctrl_0[`RCSS_PHY_MODE]) begin
      copper_res_0 = copper_lvl[phy_recovered_clock_ctrl_0[
                       `RCSS_PHY_NUM_HI:`RCSS_PHY_NUM_LO]]; // [R06]
      copper_los_0 = copper_los[phy_recovered_clock_ctrl_0[
                       `RCSS_PHY_NUM_HI:`RCSS_PHY_NUM_LO]];
    end
    if (phy_recovered_clock_ctrl_1[`RCSS_PHY_ENA] &&
        phy_recovered_clock_ctrl_1[`RCSS_PHY_FREQ] &&
        phy_recovered_clock_ctrl_1[`RCSS_PHY_MODE]) begin
      copper_res_1 = copper_lvl[phy_recovered_clock_ctrl_1[
                       `RCSS_PHY_NUM_HI:`RCSS_PHY_NUM_LO]]; // [R06]
      copper_los_1 = copper_los[phy_recovered_clock_ctrl_1[
                       `RCSS_PHY_NUM_HI:`RCSS_PHY_NUM_LO]];
    end
  end

  // Source map: 0-1 copper resources, 2-10 lanes, 11 PLL, rest unused.
  always @* begin
    source_level     = 16'h0000;
    source_los       = 16'h0000;
    source_sq_enable = 16'h0000;
    source_level[0]  = copper_res_0;
    source_level[1]  = copper_res_1;
    source_los[0]    = copper_los_0;
    source_los[1]    = copper_los_1;
    for (k = 0; k < N_LANE; k = k + 1) begin
      source_level[k + 2] = lane_lvl[k]; // [R03]
      source_los[k + 2]   = lane_los[k]; // [R12]
    end
    source_level[`RCSS_SRC_PLL] = pll_lvl; // [R10]
    source_los[`RCSS_SRC_PLL]   = 1'b0;
    source_sq_enable[`RCSS_LANE1G_N-1:0] =
      lane_1g_auto_squelch_enable; // [R13]
    source_sq_enable[`RCSS_LANE1G_N+`RCSS_LANE6G_N-1:`RCSS_LANE1G_N] =
      lane_6g_auto_squelch_enable; // [R14]
  end

  // One divider per recovered clock, each steered by its own entry.
  genvar g;
  generate
    for (g = 0; g < N_OUT; g = g + 1) begin : g_out // [R01]
      wire [3:0] src_sel = recovered_clock_config[g][
                             `RCSS_CFG_SRC_HI:`RCSS_CFG_SRC_LO];
      // Squelch needs its source's enable; lock loss also squelches
      // when the per-output lock bit is set.
      assign squelch_active[g] =
        (source_sq_enable[src_sel] &&
         (source_los[src_sel] || !lock_lvl)) || // [R12]
        (recovered_clock_pll_config[g] && !lock_lvl); // [R15]
      rcss_divider u_div (
        .pclk      (pclk),
        .presetn   (presetn),
        .src_level (source_level[src_sel]),
        .enable    (recovered_clock_config[g][`RCSS_CFG_ENA]), // [R02]
        .div_code  (recovered_clock_config[g][
                      `RCSS_CFG_DIV_HI:`RCSS_CFG_DIV_LO]),
        .squelch   (squelch_active[g]),
        .clk_out   (div_out[g])
      );
    end
  endgenerate

  // Output registers.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recovered_clock          <= 8'h00;
      recovered_clock_pin_0    <= 1'b0;
      recovered_clock_pin_0_oe <= 1'b0;
      recovered_clock_pin_1    <= 1'b0;
      recovered_clock_pin_1_oe <= 1'b0;
      highspeed_clock_pin      <= 1'b0;
    end else begin
      recovered_clock          <= div_out; // [R01]
      recovered_clock_pin_0    <= div_out[0]; // [R05]
      recovered_clock_pin_0_oe <= recovered_clock_config[0][`RCSS_CFG_ENA];
      recovered_clock_pin_1    <= div_out[1]; // [R05]
      recovered_clock_pin_1_oe <= recovered_clock_config[1][`RCSS_CFG_ENA];
      highspeed_clock_pin      <= (highspeed_output_select ==
                                   `RCSS_HS_SEL_CORE) & pll_lvl; // [R11]
    end
  end

  // APB: setup cycle prepares the answer; the access cycle that follows
  // always completes, so every transfer takes two cycles.
  assign setup_phase = psel && !penable;
  assign write_take  = psel && penable && pready && pwrite;
  assign reg_idx     = paddr[`RCSS_ADDR_IDX_HI:`RCSS_ADDR_IDX_LO];
  assign reg_grp     = paddr[`RCSS_ADDR_GRP_HI:`RCSS_ADDR_GRP_LO];

  always @* begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      next_pslverr = 1'b1;
    end else if (reg_grp == `RCSS_GRP_CFG) begin
      next_prdata[7:0] = recovered_clock_config[reg_idx];
    end else if (reg_grp == `RCSS_GRP_PLLCFG) begin
      next_prdata[`RCSS_PLLCFG_LOCKSQ] = recovered_clock_pll_config[reg_idx];
    end else begin
      case (paddr)
        `RCSS_ADDR_HSOUT:    next_prdata[1:0] = highspeed_output_select;
        `RCSS_ADDR_PHYCTRL0: next_prdata[4:0] = phy_recovered_clock_ctrl_0;
        `RCSS_ADDR_PHYCTRL1: next_prdata[4:0] = phy_recovered_clock_ctrl_1;
        `RCSS_ADDR_LANE1G:   next_prdata[5:0] = lane_1g_auto_squelch_enable;
        `RCSS_ADDR_LANE6G:   next_prdata[2:0] = lane_6g_auto_squelch_enable;
        `RCSS_ADDR_STATUS: begin
          next_prdata[8:0]   = lane_los;
          next_prdata[12:9]  = copper_los;
          next_prdata[13]    = lock_lvl;
          next_prdata[23:16] = squelch_active;
        end
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pready  <= 1'b1;
      pslverr <= next_pslverr || (pwrite && paddr == `RCSS_ADDR_STATUS);
    end else begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Register writes land only in the addressed entry.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (j = 0; j < N_OUT; j = j + 1) begin
        recovered_clock_config[j] <= `RCSS_CFG_RESET;
      end
      recovered_clock_pll_config  <= 8'h00;
      highspeed_output_select     <= `RCSS_HS_SEL_OFF;
      phy_recovered_clock_ctrl_0  <= `RCSS_PHY_RESET;
      phy_recovered_clock_ctrl_1  <= `RCSS_PHY_RESET;
      lane_1g_auto_squelch_enable <= 6'h00;
      lane_6g_auto_squelch_enable <= 3'h0;
    end else if (write_take && !pslverr) begin
      if (reg_grp == `RCSS_GRP_CFG) begin
        recovered_clock_config[reg_idx] <= pwdata[7:0]; // [R17]
      end else if (reg_grp == `RCSS_GRP_PLLCFG) begin
        recovered_clock_pll_config[reg_idx] <=
          pwdata[`RCSS_PLLCFG_LOCKSQ];
      end else begin
        case (paddr)
          `RCSS_ADDR_HSOUT:    highspeed_output_select <= pwdata[1:0];
          `RCSS_ADDR_PHYCTRL0: phy_recovered_clock_ctrl_0 <= pwdata[4:0];
          `RCSS_ADDR_PHYCTRL1: phy_recovered_clock_ctrl_1 <= pwdata[4:0];
          `RCSS_ADDR_LANE1G:   lane_1g_auto_squelch_enable <= pwdata[5:0];
          `RCSS_ADDR_LANE6G:   lane_6g_auto_squelch_enable <= pwdata[2:0];
          default: ;
        endcase
      end
    end
  end

endmodule // rcss_top

`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the recovered clock block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, pll_clock = 0, pll_lock = 1;
  logic [3:0] copper_phy_rx_clock = 4'h0, copper_phy_loss_of_signal = 4'h0;
  logic [8:0] lane_rx_clock = 9'h000, lane_loss_of_signal = 9'h000;
  logic [7:0] recovered_clock, rc_q = 8'h00;
  logic pin0, pin0_oe, pin1, pin1_oe, hs_pin;
  logic [2:0] pin_w;
  int rise [3], per [3], rc_rise [8] = '{default: 0};
  int n_errors = 0, tests_run = 0, cyc = 0;
  int divs [8] = '{1, 2, 4, 5, 8, 16, 25, 1};
  rcss_top i_rcss_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .copper_phy_rx_clock,
    .lane_rx_clock, .pll_clock, .pll_lock, .lane_loss_of_signal,
    .copper_phy_loss_of_signal, .recovered_clock,
    .recovered_clock_pin_0(pin0), .recovered_clock_pin_0_oe(pin0_oe),
    .recovered_clock_pin_1(pin1), .recovered_clock_pin_1_oe(pin1_oe),
    .highspeed_clock_pin(hs_pin));
  // Released GPIO pins are taken as pulled low on the board.
  assign pin_w = {hs_pin, pin1_oe & pin1, pin0_oe & pin0};
  rcss_timing_model i_rcss_timing_model (.pclk, .clk_pin(pin_w), .rise,
    .per);
  always #2.5 pclk = ~pclk;
  // Sources: lane i period 24+2i, copper i period 14+2i, PLL period 20.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    rc_q <= recovered_clock;
    pll_clock <= (cyc / 10) % 2 == 1;
    for (int i = 0; i < 9; i++) lane_rx_clock[i] <= (cyc / (12 + i)) % 2 == 1;
    for (int i = 0; i < 4; i++)
      copper_phy_rx_clock[i] <= (cyc / (7 + i)) % 2 == 1;
    for (int i = 0; i < 8; i++)
      if (recovered_clock[i] && !rc_q[i]) rc_rise[i] <= rc_rise[i] + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  function automatic logic [31:0] cfg(input logic [3:0] s,
                                      input logic [2:0] dv, input logic en);
    return {24'h0, s, dv, en};
  endfunction
  // Checks whether pin p keeps toggling over a window.
  task automatic runs(input int p, input logic x);
    int e0;
    repeat (40) @(posedge pclk);
    e0 = rise[p];
    repeat (300) @(posedge pclk);
    chk({31'h0, rise[p] != e0}, {31'h0, x});
  endtask
  task automatic per_is(input int p, input int x);
    repeat (3 * x + 40) @(posedge pclk);
    chk(per[p], x);
  endtask
  task automatic t_reset();
    chk({recovered_clock, pin0_oe, pin1_oe, hs_pin}, 32'h0000_0000);
    for (int n = 0; n < 8; n++) rd(8'(4 * n), 32'h0000_0000, 1'b0);
    rd(8'h58, 32'h0000_0000, 1'b1);
    rd(8'h01, 32'h0000_0000, 1'b1);
    wr(8'h54, 32'h0000_FFFF, 1'b1);
    rd(8'h54, 32'h0000_2000, 1'b0);
  endtask
  task automatic t_regs();
    for (int n = 0; n < 8; n++) wr(8'(4 * n), 32'(8'h11 * n + 1), 1'b0);
    for (int n = 0; n < 8; n++) wr(8'(32 + 4 * n), 32'(n % 2), 1'b0);
    for (int n = 0; n < 8; n++) rd(8'(4 * n), 32'(8'h11 * n + 1), 1'b0);
    for (int n = 0; n < 8; n++) rd(8'(32 + 4 * n), 32'(n % 2), 1'b0);
    for (int n = 0; n < 16; n++) wr(8'(4 * n), 32'h0000_0000, 1'b0);
  endtask
  task automatic t_div();
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, cfg(4'h2, 3'(c), 1'b1), 1'b0);
      per_is(0, 24 * divs[c]);
    end
    chk({31'h0, pin0_oe}, 32'h0000_0001);
    wr(8'h04, cfg(4'hA, 3'h2, 1'b1), 1'b0);
    per_is(1, 160);
    wr(8'h00, cfg(4'hB, 3'h0, 1'b1), 1'b0);
    per_is(0, 20);
  endtask
  task automatic t_src();
    for (int l = 0; l < 9; l++) begin
      wr(8'h00, cfg(4'(l + 2), 3'h0, 1'b1), 1'b0);
      per_is(0, 24 + 2 * l);
    end
    wr(8'h44, 32'h0000_001F, 1'b0);
    wr(8'h00, cfg(4'h0, 3'h0, 1'b1), 1'b0);
    per_is(0, 20);
    wr(8'h48, 32'h0000_001B, 1'b0);
    wr(8'h04, cfg(4'h1, 3'h0, 1'b1), 1'b0);
    per_is(1, 16);
    wr(8'h48, 32'h0000_0013, 1'b0);
    runs(1, 1'b0);
  endtask
  task automatic t_squelch();
    wr(8'h00, cfg(4'h2, 3'h0, 1'b1), 1'b0);
    lane_loss_of_signal[0] <= 1'b1;
    runs(0, 1'b1);
    wr(8'h4C, 32'h0000_0004, 1'b0);
    runs(0, 1'b0);
    rd(8'h54, 32'h0001_2001, 1'b0);
    lane_loss_of_signal[0] <= 1'b0;
    runs(0, 1'b1);
    wr(8'h04, cfg(4'h6, 3'h0, 1'b1), 1'b0);
    wr(8'h50, 32'h0000_0001, 1'b0);
    lane_loss_of_signal[4] <= 1'b1;
    runs(1, 1'b0);
    lane_loss_of_signal[4] <= 1'b0;
    wr(8'h50, 32'h0000_0000, 1'b0);
    wr(8'h00, cfg(4'hB, 3'h0, 1'b1), 1'b0);
    wr(8'h20, 32'h0000_0001, 1'b0);
    pll_lock <= 1'b0;
    runs(0, 1'b0);
    pll_lock <= 1'b1;
    runs(0, 1'b1);
  endtask
  task automatic t_out();
    int e0 [8];
    wr(8'h40, 32'h0000_0001, 1'b0);
    per_is(2, 20);
    wr(8'h40, 32'h0000_0002, 1'b0);
    runs(2, 1'b0);
    for (int n = 0; n < 8; n++) wr(8'(4 * n), cfg(4'hB, 3'h0, 1'b1), 1'b0);
    repeat (40) @(posedge pclk);
    e0 = rc_rise;
    repeat (100) @(posedge pclk);
    for (int n = 0; n < 8; n++)
      chk(32'(rc_rise[n] > e0[n]), 32'h0000_0001);
    wr(8'h00, cfg(4'hB, 3'h0, 1'b0), 1'b0);
    runs(0, 1'b0);
    chk({31'h0, recovered_clock[0]}, 32'h0000_0000);
    per_is(1, 20);
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_div();
    t_src();
    t_squelch();
    t_out();
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
